//--- hdl/sync_serial_port_pkg.sv
package sync_serial_port_pkg;

   // Buffer geometry
   localparam int FIFO_DEPTH = 8;
   localparam int DATA_W = 16;

   // Frame size limits, programmed as size minus one
   localparam logic [3:0] SIZE_M1_MIN = 4'h3;
   localparam logic [3:0] SIZE_M1_MAX = 4'hF;

   // Command phase length of the command-then-response format
   localparam logic [4:0] CMD_BITS = 5'h08;

   // Shifter holds command plus largest response
   localparam int SHIFT_W = 24;

   // Reset values of pins and shifters
   localparam logic SCLK_RST = 1'b0;
   localparam logic FSS_RST = 1'b1;
   localparam logic [SHIFT_W-1:0] SHIFT_RST = 24'h000000;

   // Frame formats
   typedef enum logic [1:0]
   {
      FMT_SPI = 2'b00,
      FMT_SYNC_PULSE = 2'b01,
      FMT_CMD_RESP = 2'b10
   } fmt_t;

   // Engine states, one-hot
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_SYNC = 4'b0010,
      ST_RUN = 4'b0100,
      ST_GAP = 4'b1000
   } state_t;

endpackage : sync_serial_port_pkg

//--- hdl/sync_serial_port.sv
module sync_serial_port
#(
   parameter int DEPTH = sync_serial_port_pkg::FIFO_DEPTH,
   parameter int DW = sync_serial_port_pkg::DATA_W
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cfg_enable,
   input wire logic cfg_master,
   input wire logic cfg_slave_out_dis,
   input wire logic cfg_loopback,
   input wire logic [1:0] cfg_format,
   input wire logic [3:0] cfg_size_m1,
   input wire logic cfg_cpol,
   input wire logic cfg_cpha,
   input wire logic [7:0] cfg_prescale,
   input wire logic [7:0] cfg_rate_div,
   input wire logic [DW-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [DW-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic busy,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   input wire logic fss_in,
   output logic fss_out,
   output logic fss_oe,
   input wire logic rxd_in,
   output logic txd_out,
   output logic txd_oe
);
   import sync_serial_port_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   // Place word MSB-first at shifter top, command format aware
   function automatic logic [SHIFT_W-1:0] align_tx(
      input logic [DW-1:0] word,
      input logic [4:0] nbits,
      input logic cmd_slave,
      input logic cmd_master
   );
      logic [SHIFT_W-1:0] wide;
      wide = {word, 8'h00};
      if (cmd_master)
         align_tx = {word[7:0], 16'h0000};
      else if (cmd_slave)
         align_tx = {8'h00, wide[SHIFT_W-1:8] << (5'h10 - nbits)};
      else
         align_tx = wide << (5'h10 - nbits);
   endfunction : align_tx

   // Clear bits above the frame size
   function automatic logic [DW-1:0] trim(
      input logic [DW-1:0] word,
      input logic [4:0] nbits
   );
      trim = word & DW'((17'h00001 << nbits) - 17'h00001);
   endfunction : trim

   // Pin synchronisers, stage three only feeds edge detection
   logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
   logic fss_s1_ff, fss_s2_ff;
   logic rxd_s1_ff, rxd_s2_ff;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_s1_ff <= SCLK_RST;
         sclk_s2_ff <= SCLK_RST;
         sclk_s3_ff <= SCLK_RST;
         fss_s1_ff <= FSS_RST;
         fss_s2_ff <= FSS_RST;
         rxd_s1_ff <= 1'b0;
         rxd_s2_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         sclk_s1_ff <= sclk_in;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_s3_ff <= sclk_s2_ff;
         fss_s1_ff <= fss_in;
         fss_s2_ff <= fss_s1_ff;
         rxd_s1_ff <= rxd_in;
         rxd_s2_ff <= rxd_s1_ff;
      end
   end

   // Transmit buffer storage and pointers
   logic [DW-1:0] tx_mem [DEPTH];
   logic [AW-1:0] tx_wr_ff, tx_rd_ff, nxt_tx_wr, nxt_tx_rd;
   logic [CW-1:0] tx_cnt_ff, nxt_tx_cnt;
   logic tx_ready_ff, nxt_tx_ready;
   logic tx_push, tx_pop;  // Pop comes from the engine

   // Transmit buffer next state; ready is the back-pressure
   always_comb
   begin
      tx_push = tx_valid && tx_ready_ff;
      nxt_tx_wr = tx_push ? tx_wr_ff + 1'b1 : tx_wr_ff;
      nxt_tx_rd = tx_pop ? tx_rd_ff + 1'b1 : tx_rd_ff;
      nxt_tx_cnt = tx_cnt_ff + CW'(tx_push) - CW'(tx_pop);
      nxt_tx_ready = nxt_tx_cnt < FULL_CNT;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_wr_ff <= '0;
         tx_rd_ff <= '0;
         tx_cnt_ff <= '0;
         tx_ready_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         tx_wr_ff <= nxt_tx_wr;
         tx_rd_ff <= nxt_tx_rd;
         tx_cnt_ff <= nxt_tx_cnt;
         tx_ready_ff <= nxt_tx_ready;
      end
   end

   // Storage write, no reset needed for data
   always_ff @(posedge core_clk)
   begin
      if (clk_en && tx_push)
         tx_mem[tx_wr_ff] <= tx_data;
   end

   // Receive buffer storage and pointers
   logic [DW-1:0] rx_mem [DEPTH];
   logic [AW-1:0] rx_wr_ff, rx_rd_ff, nxt_rx_wr, nxt_rx_rd;
   logic [CW-1:0] rx_cnt_ff, nxt_rx_cnt;
   logic rx_valid_ff, nxt_rx_valid;
   logic [DW-1:0] rx_data_ff, nxt_rx_data;
   logic rx_push, rx_put, rx_take;
   logic [DW-1:0] rx_word; // Completed frame from the engine

   // Receive buffer next state; a full buffer drops the new frame
   always_comb
   begin
      rx_put = rx_push && (rx_cnt_ff != FULL_CNT);
      rx_take = rx_ready && rx_valid_ff;
      nxt_rx_wr = rx_put ? rx_wr_ff + 1'b1 : rx_wr_ff;
      nxt_rx_rd = rx_take ? rx_rd_ff + 1'b1 : rx_rd_ff;
      nxt_rx_cnt = rx_cnt_ff + CW'(rx_put) - CW'(rx_take);
      nxt_rx_valid = nxt_rx_cnt != '0;
      // Head may be the word written this very cycle
      if (!nxt_rx_valid)
         nxt_rx_data = '0;
      else if (rx_put && nxt_rx_rd == rx_wr_ff)
         nxt_rx_data = rx_word;
      else
         nxt_rx_data = rx_mem[nxt_rx_rd];
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wr_ff <= '0;
         rx_rd_ff <= '0;
         rx_cnt_ff <= '0;
         rx_valid_ff <= 1'b0;
         rx_data_ff <= '0;
      end
      else if (clk_en)
      begin
         rx_wr_ff <= nxt_rx_wr;
         rx_rd_ff <= nxt_rx_rd;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_valid_ff <= nxt_rx_valid;
         rx_data_ff <= nxt_rx_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (clk_en && rx_put)
         rx_mem[rx_wr_ff] <= rx_word;
   end

   // Serial engine state
   state_t st_ff, nxt_st;
   logic sclk_ff, nxt_sclk, fss_ff, nxt_fss;
   logic txd_ff, nxt_txd, txd_oe_ff, nxt_txd_oe, busy_ff;
   logic [SHIFT_W-1:0] tx_sh_ff, nxt_tx_sh;
   logic [DW-1:0] rx_sh_ff, nxt_rx_sh;
   logic [5:0] edge_cnt_ff, nxt_edge_cnt;
   logic [4:0] smp_cnt_ff, nxt_smp_cnt;
   logic first_ff, nxt_first;
   logic [7:0] pre_cnt_ff, nxt_pre_cnt, div_cnt_ff, nxt_div_cnt;

   // Decoded configuration and edge events
   fmt_t fmt;
   logic [4:0] nbits, total;
   logic idle_lvl, smp_lead, tick, edge_ev, lead, smp_ev, sh_ev;
   logic rx_bit, rx_act, last_edge, cmd;
   logic [SHIFT_W-1:0] load_val;

   always_comb
   begin
      fmt = (cfg_format == FMT_SYNC_PULSE) ? FMT_SYNC_PULSE :
            (cfg_format == FMT_CMD_RESP) ? FMT_CMD_RESP : FMT_SPI;
      cmd = fmt == FMT_CMD_RESP;
      // Sizes under four are raised to four
      nbits = {1'b0, (cfg_size_m1 < SIZE_M1_MIN) ? SIZE_M1_MIN :
               cfg_size_m1} + 5'h01;
      total = cmd ? nbits + CMD_BITS : nbits;
      idle_lvl = (fmt == FMT_SPI) ? cfg_cpol : 1'b0;
      smp_lead = (fmt == FMT_SPI) ? !cfg_cpha : cmd;
      load_val = align_tx(tx_cnt_ff != '0 ? tx_mem[tx_rd_ff] : '0, nbits,
                          cmd && !cfg_master, cmd && cfg_master);
      // Prescaler then bit divider; prescaler divides by its setting, bit divider by its setting plus one
      tick = (pre_cnt_ff >= cfg_prescale - 8'h01 || cfg_prescale == '0)
             && div_cnt_ff >= cfg_rate_div;
      // Master edges from own clock, slave from synchronised pin
      if (cfg_master)
         edge_ev = (st_ff == ST_RUN) && tick;
      else
         edge_ev = (st_ff == ST_RUN) && (sclk_s2_ff != sclk_s3_ff);
      lead = cfg_master ? (sclk_ff == idle_lvl) : (sclk_s2_ff != idle_lvl);
      smp_ev = edge_ev && (lead == smp_lead);
      sh_ev = edge_ev && (lead != smp_lead);
      last_edge = edge_ev && (edge_cnt_ff == {total, 1'b0} - 6'h01);
      rx_bit = cfg_loopback ? txd_ff : rxd_s2_ff;
      if (cmd)
         rx_act = cfg_master ? (smp_cnt_ff >= CMD_BITS)
                             : (smp_cnt_ff < CMD_BITS);
      else
         rx_act = 1'b1;
   end

   // Engine next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_sclk = sclk_ff;
      nxt_fss = fss_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_edge_cnt = edge_cnt_ff;
      nxt_smp_cnt = smp_cnt_ff;
      nxt_first = first_ff;
      nxt_pre_cnt = pre_cnt_ff + 8'h01;
      nxt_div_cnt = div_cnt_ff;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_word = '0;
      // Divider chain runs only while the master is busy
      if (st_ff == ST_IDLE || !cfg_master)
      begin
         nxt_pre_cnt = '0;
         nxt_div_cnt = '0;
      end
      else if (pre_cnt_ff >= cfg_prescale - 8'h01 || cfg_prescale == '0)
      begin
         nxt_pre_cnt = '0;
         nxt_div_cnt = tick ? 8'h00 : div_cnt_ff + 8'h01;
      end
      if (edge_ev)
      begin
         nxt_sclk = ~sclk_ff;
         nxt_edge_cnt = edge_cnt_ff + 6'h01;
      end
      if (smp_ev)
      begin
         nxt_smp_cnt = smp_cnt_ff + 5'h01;
         if (rx_act)
            nxt_rx_sh = {rx_sh_ff[DW-2:0], rx_bit};
      end
      // First shift edge is skipped when shifting on the lead
      if (sh_ev)
      begin
         nxt_first = 1'b0;
         if (!(first_ff && !smp_lead))
            nxt_tx_sh = {tx_sh_ff[SHIFT_W-2:0], 1'b0};
      end
      unique case (st_ff)
         ST_IDLE:
         begin
            nxt_sclk = idle_lvl;
            nxt_fss = fmt != FMT_SYNC_PULSE;
            nxt_edge_cnt = '0;
            nxt_smp_cnt = '0;
            nxt_first = 1'b1;
            nxt_rx_sh = '0;
            // Master starts on a queued word; slave on frame select
            if (cfg_enable && cfg_master && tx_cnt_ff != '0)
            begin
               tx_pop = 1'b1;
               nxt_tx_sh = load_val;
               nxt_fss = fmt == FMT_SYNC_PULSE;
               nxt_st = (fmt == FMT_SYNC_PULSE) ? ST_SYNC : ST_RUN;
            end
            else if (cfg_enable && !cfg_master &&
                     fss_s2_ff == (fmt == FMT_SYNC_PULSE))
            begin
               // Empty buffer sends zeros rather than stale data
               tx_pop = tx_cnt_ff != '0;
               nxt_tx_sh = load_val;
               nxt_st = (fmt == FMT_SYNC_PULSE) ? ST_SYNC : ST_RUN;
            end
         end
         ST_SYNC:
         begin
            // Pulse lasts two half periods, no clock edges meanwhile
            if (cfg_master && tick)
            begin
               nxt_edge_cnt = edge_cnt_ff + 6'h01;
               if (edge_cnt_ff[0])
               begin
                  nxt_fss = 1'b0;
                  nxt_edge_cnt = '0;
                  nxt_st = ST_RUN;
               end
            end
            else if (!cfg_master && !fss_s2_ff)
               nxt_st = ST_RUN;
         end
         ST_RUN:
         begin
            if (last_edge)
            begin
               rx_push = 1'b1;
               rx_word = trim(nxt_rx_sh, cmd && !cfg_master ?
                              CMD_BITS : nbits);
               nxt_fss = fmt != FMT_SYNC_PULSE;
               nxt_st = ST_GAP;
            end
            else if (!cfg_master && fmt != FMT_SYNC_PULSE && fss_s2_ff)
               nxt_st = ST_IDLE;  // Select lost: frame abandoned
         end
         ST_GAP:
         begin
            // Master idles a half period; slave waits for deselect, or returns at once in sync-pulse format
            if (cfg_master ? tick : (fmt == FMT_SYNC_PULSE || fss_s2_ff))
               nxt_st = ST_IDLE;
         end
      endcase
      if (!cfg_enable)
         nxt_st = ST_IDLE;
      nxt_txd = nxt_tx_sh[SHIFT_W-1];
      // Slave drives only while selected and not disabled
      nxt_txd_oe = cfg_enable && (cfg_master ||
                   (!cfg_slave_out_dis && nxt_st != ST_IDLE));
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= ST_IDLE;
         sclk_ff <= SCLK_RST;
         fss_ff <= FSS_RST;
         txd_ff <= 1'b0;
         txd_oe_ff <= 1'b0;
         busy_ff <= 1'b0;
         tx_sh_ff <= SHIFT_RST;
         rx_sh_ff <= '0;
         edge_cnt_ff <= '0;
         smp_cnt_ff <= '0;
         first_ff <= 1'b1;
         pre_cnt_ff <= '0;
         div_cnt_ff <= '0;
      end
      else if (clk_en)
      begin
         st_ff <= nxt_st;
         sclk_ff <= nxt_sclk;
         fss_ff <= nxt_fss;
         txd_ff <= nxt_txd;
         txd_oe_ff <= nxt_txd_oe;
         busy_ff <= nxt_st != ST_IDLE;
         tx_sh_ff <= nxt_tx_sh;
         rx_sh_ff <= nxt_rx_sh;
         edge_cnt_ff <= nxt_edge_cnt;
         smp_cnt_ff <= nxt_smp_cnt;
         first_ff <= nxt_first;
         pre_cnt_ff <= nxt_pre_cnt;
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // Master pins enables; all outputs straight from flip-flops
   logic mst_oe_ff;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mst_oe_ff <= 1'b0;
      else if (clk_en)
         mst_oe_ff <= cfg_enable && cfg_master;
   end

   assign tx_ready = tx_ready_ff;
   assign rx_data = rx_data_ff;
   assign rx_valid = rx_valid_ff;
   assign busy = busy_ff;
   assign sclk_out = sclk_ff;
   assign sclk_oe = mst_oe_ff;
   assign fss_out = fss_ff;
   assign fss_oe = mst_oe_ff;
   assign txd_out = txd_ff;
   assign txd_oe = txd_oe_ff;

endmodule : sync_serial_port

//--- tb/sync_serial_port_monitor.sv
module sync_serial_port_monitor
#(
   parameter int DW = 16
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cfg_enable,
   input wire logic cfg_master,
   input wire logic cfg_slave_out_dis,
   input wire logic [1:0] cfg_format,
   input wire logic [3:0] cfg_size_m1,
   input wire logic cfg_cpol,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [DW-1:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic busy,
   input wire logic sclk_out,
   input wire logic sclk_oe,
   input wire logic fss_out,
   input wire logic fss_oe,
   input wire logic txd_oe
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   property p_slave_quiet;
      (!cfg_master && cfg_slave_out_dis)[*3] |-> !txd_oe;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet)
      else $error("txd driven by muted slave");
   property p_slave_no_clk;
      (!cfg_master)[*3] |-> !sclk_oe && !fss_oe;
   endproperty
   a_slave_no_clk: assert property (p_slave_no_clk)
      else $error("slave drives clock or select");
   property p_master_drive;
      (cfg_master && cfg_enable)[*3] |-> sclk_oe && fss_oe;
   endproperty
   a_master_drive: assert property (p_master_drive)
      else $error("master leaves clock or select undriven");
   property p_tx_fall;
      $fell(tx_ready) |-> $past(tx_valid);
   endproperty
   a_tx_fall: assert property (p_tx_fall)
      else $error("tx_ready fell without a push");
   property p_rx_hold;
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("receive head lost before pop");
   // Size is kept steady while words wait, so it still applies
   property p_upper_zero;
      rx_valid && cfg_size_m1 >= 4'h3 |->
         (rx_data >> ({1'b0, cfg_size_m1} + 5'h01)) == '0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused upper receive bits not zero");
   property p_sclk_still;
      ($stable(cfg_cpol) && !busy)[*3] |-> $stable(sclk_out);
   endproperty
   a_sclk_still: assert property (p_sclk_still)
      else $error("serial clock moves while idle");
   property p_fss_idle;
      (cfg_master && cfg_enable && !busy && cfg_format == 2'b00)[*3]
         |-> fss_out;
   endproperty
   a_fss_idle: assert property (p_fss_idle)
      else $error("select not high while idle");
endmodule : sync_serial_port_monitor

bind sync_serial_port sync_serial_port_monitor #(.DW(DW)) u_mon
(
   .core_clk, .rst_n, .cfg_enable, .cfg_master, .cfg_slave_out_dis,
   .cfg_format, .cfg_size_m1, .cfg_cpol, .tx_valid, .tx_ready, .rx_data,
   .rx_valid, .rx_ready, .busy, .sclk_out, .sclk_oe, .fss_out, .fss_oe,
   .txd_oe
);

//--- tb/serial_peer.sv
module serial_peer
(
   input wire logic sclk,
   input wire logic fss,
   input wire logic mosi,
   input wire logic lead,
   input wire logic [4:0] skip,
   input wire logic [4:0] nbits,
   input wire logic [15:0] word,
   output logic miso,
   output logic [23:0] got
);
   timeunit 1ns;
   timeprecision 1ns;
   int s; // Sample edges in this frame
   int e; // Clock edges in this frame
   int k;
   // Reply bit due now; outside the reply a toggling filler
   task automatic drive();
      k = s - skip;
      if (k >= 0 && k < nbits)
         miso = word[nbits - 1 - k];
      else
         miso = ~miso;
   endtask : drive
   initial
   begin
      miso = 1'b0;
      got = 24'h000000;
   end
   // Every format opens its data on a falling select
   always @(negedge fss)
   begin
      s = 0;
      e = 0;
      got = 24'h000000;
      drive();
   end
   // Sample on the agreed edge, shift on the other
   always @(sclk)
   begin
      if ((e % 2 == 0) == lead)
      begin
         got = {got[22:0], mosi};
         s++;
      end
      else
         drive();
      e++;
   end
endmodule : serial_peer

//--- tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sync_serial_port_pkg::*;
   logic core_clk, rst_n, clk_en, cfg_enable, cfg_master, cfg_slave_out_dis;
   logic cfg_loopback, cfg_cpol, cfg_cpha, tx_valid, rx_ready;
   logic [1:0] cfg_format;
   logic [3:0] cfg_size_m1;
   logic [7:0] cfg_prescale, cfg_rate_div;
   logic [15:0] tx_data, rx_data, peer_word, m;
   logic tx_ready, rx_valid, busy, sclk_out, sclk_oe, fss_out, fss_oe;
   logic txd_out, txd_oe, b_sclk, b_fss, b_rxd, peer_miso, sclk_last;
   logic [23:0] peer_got;
   int err_total = 0, total_checks = 0, cycles = 0, hp_cnt = 0, hp_seen = 0;
   int p, d, n;
   int q[$]; // Expected receive words in order
   // Wire levels from whoever drives them
   wire sclk_line = sclk_oe ? sclk_out : b_sclk;
   wire fss_line = fss_oe ? fss_out : b_fss;
   wire rxd_line = cfg_master ? peer_miso : b_rxd;
   wire lead = (cfg_format == 2'b01) ? 1'b0 :
               (cfg_format == 2'b10) ? 1'b1 : !cfg_cpha;
   wire [4:0] skip = (cfg_format == 2'b10) ? CMD_BITS : 5'h00;
   wire [4:0] nbits = {1'b0, cfg_size_m1} + 5'h01;

   sync_serial_port u_dut (.core_clk, .rst_n, .clk_en, .cfg_enable,
      .cfg_master, .cfg_slave_out_dis, .cfg_loopback, .cfg_format,
      .cfg_size_m1, .cfg_cpol, .cfg_cpha, .cfg_prescale, .cfg_rate_div,
      .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy,
      .sclk_in(sclk_line), .sclk_out, .sclk_oe, .fss_in(fss_line), .fss_out,
      .fss_oe, .rxd_in(rxd_line), .txd_out, .txd_oe);
   serial_peer u_peer (.sclk(sclk_line), .fss(fss_line), .mosi(txd_out),
      .lead, .skip, .nbits, .word(peer_word), .miso(peer_miso),
      .got(peer_got));

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Half period seen between clock toggles; also the hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      hp_cnt++;
      if (sclk_out !== sclk_last)
      begin
         hp_seen = hp_cnt;
         hp_cnt = 0;
         sclk_last = sclk_out;
      end
      if (cycles == 80000)
      begin
         err_total++;
         stop_test();
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // Hold the word until the edge that takes it
   task automatic push(input logic [15:0] w);
      tx_data = w;
      tx_valid = 1'b1;
      do
         @(posedge core_clk);
      while (tx_ready !== 1'b1);
      @(negedge core_clk);
      tx_valid = 1'b0;
   endtask : push
   task automatic pop(input logic [15:0] exp);
      repeat (3000) if (rx_valid !== 1'b1) @(negedge core_clk);
      check(rx_data, exp);
      rx_ready = 1'b1;
      @(negedge core_clk);
      rx_ready = 1'b0;
   endtask : pop
   // Random size and rate; only called while idle
   task automatic setup(input int fmt, input int mode, input logic lb);
      p = $urandom_range(4, 2);
      d = $urandom_range(2, 1);
      n = $urandom_range(16, 4);
      m = 16'((1 << n) - 1);
      cfg_format = 2'(fmt);
      cfg_cpol = mode[0];
      cfg_cpha = mode[1];
      cfg_loopback = lb;
      cfg_prescale = 8'(p);
      cfg_rate_div = 8'(d);
      cfg_size_m1 = 4'(n - 1);
      peer_word = 16'($urandom);
      @(negedge core_clk);
   endtask : setup
   task automatic frame(input int fmt, input int mode, input logic lb);
      logic [15:0] w;
      setup(fmt, mode, lb);
      w = 16'($urandom);
      q.push_back(lb ? w & m : peer_word & m);
      push(w);
      pop(16'(q.pop_front()));
      repeat (4000) if (busy !== 1'b0) @(negedge core_clk);
      check(24'(hp_seen), 24'(p * (d + 1)));
      check(fmt == 2 ? peer_got >> n : peer_got,
            fmt == 2 ? 24'(w[7:0]) : 24'(w & m));
   endtask : frame

   initial
   begin
      logic [15:0] w;
      int idle;
      rst_n = 1'b0;
      {clk_en, cfg_enable, cfg_master} = 3'b111;
      {cfg_slave_out_dis, tx_valid, rx_ready} = 3'b000;
      {b_sclk, b_fss, b_rxd} = 3'b010;
      tx_data = 16'h0000;
      void'($urandom(32'hFA6848D4));
      setup(0, 0, 0);
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      // All formats and clock modes, then loopback on the spare code
      for (int r = 0; r < 3; r++)
         for (int k = 0; k < 7; k++)
            frame(k < 4 ? 0 : k - 3, k, k == 6);
      // Fill transmit while stopped, overrun receive, drain
      setup(0, 0, 1);
      cfg_enable = 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         w = 16'($urandom);
         if (i < 8)
            q.push_back(w & m);
         else
         begin
            @(negedge core_clk);
            check(tx_ready, 1'b0);
            cfg_enable = 1'b1;
         end
         push(w);
      end
      idle = 0;
      while (idle < 100)
      begin
         @(negedge core_clk);
         idle = busy ? 0 : idle + 1;
      end
      repeat (8) pop(16'(q.pop_front()));
      check(rx_valid, 1'b0);
      // Muted slave clocked by the bench
      setup(0, 0, 0);
      cfg_master = 1'b0;
      cfg_slave_out_dis = 1'b1;
      w = 16'($urandom);
      b_fss = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         b_rxd = w[i];
         repeat (6) @(negedge core_clk);
         b_sclk = 1'b1;
         repeat (6) @(negedge core_clk);
         b_sclk = 1'b0;
      end
      repeat (6) @(negedge core_clk);
      b_fss = 1'b1;
      pop(w & m);
      // Frozen master must not take an offered word
      cfg_master = 1'b1;
      repeat (4) @(negedge core_clk);
      clk_en = 1'b0;
      tx_data = 16'(w);
      tx_valid = 1'b1;
      repeat (5) @(negedge core_clk);
      tx_valid = 1'b0;
      clk_en = 1'b1;
      repeat (4) @(negedge core_clk);
      check(busy, 1'b0);
      check(rx_valid, 1'b0);
      stop_test();
   end
endmodule : testbench
